/* tb/dsp_interrupt_vectoring_tb_top.sv */
`timescale 1ns/1ns
`include "dspiv_regs.vh"
module dsp_interrupt_vectoring_tb_top;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, nmi = 0, slow = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, rd;
	logic [16:0] src = 0;
	logic        err;
	wire         pready, pslverr, req, ack;
	wire  [31:0] prdata;
	wire  [4:0]  trap, ktrap;
	wire  [7:0]  kcnt;
	int          miscompares = 0, tests_run = 0, seen = 0, b;
	initial forever #2 pclk = ~pclk;
	dspiv_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr, .nmi_request(nmi), .external_request_zero(src[0]),
		.external_request_one(src[1]), .external_request_two(src[2]),
		.timer_zero_request(src[3]), .serial_zero_receive_request(src[4]),
		.serial_zero_transmit_request(src[5]), .dma_chan_zero_request(src[6]),
		.timer_one_request(src[7]), .external_request_three(src[8]),
		.host_port_request(src[9]), .serial_one_receive_request(src[10]),
		.serial_one_transmit_request(src[11]), .dma_chan_four_request(src[12]),
		.dma_chan_five_request(src[13]), .dma_chan_one_request(src[14]),
		.dma_chan_two_request(src[15]), .dma_chan_three_request(src[16]),
		.core_int_req(req), .core_int_trap(trap), .core_int_vector(), .core_int_ack(ack));
	dspiv_core_model u_core (.pclk, .presetn, .slow, .core_int_req(req), .core_int_trap(trap),
		.core_int_ack(ack), .taken_trap(ktrap), .taken_cnt(kcnt));
	// ----
	// Tasks
	// ----
	task chk(input string nm, input [31:0] e, input [31:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task apb(input logic w, input [11:0] a, input [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdc(input string nm, input [11:0] a, input [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask
	task take(input [4:0] e);
		int n;
		seen++;
		n = 0;
		while (kcnt !== seen[7:0] && n < 60) begin
			@(posedge pclk);
			n++;
		end
		chk("trap", {27'h0, e}, {27'h0, ktrap});
		chk("count", seen, {24'h0, kcnt});
	endtask
	task none();
		repeat (12) @(posedge pclk);
		chk("count", seen, {24'h0, kcnt});
	endtask
	task pulsev(input [16:0] v);
		@(posedge pclk);
		src <= v;
		@(posedge pclk);
		src <= 17'h0;
	endtask
	function int route(int i, int s);
		case (i)
			6: return s ? 6 : -1;
			7, 10, 11: return s ? -1 : i;
			14: return s ? 7 : -1;
			15, 16: return s ? i - 5 : -1;
			default: return i;
		endcase
	endfunction
	task tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ----
	// Tests
	// ----
	initial begin
		#40000;
		miscompares++;
		tally_and_finish();
	end
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		take(5'd0);
		rdc("flags", `DSPIV_OFS_FLAGS, 32'h0);
		rdc("mask", `DSPIV_OFS_MASK, 32'h0);
		rdc("dmactl", `DSPIV_OFS_DMACTL, 32'h0);
		apb(1'b1, 12'h0F0, 32'h1);
		chk("pslverr", 32'h1, {31'h0, err});
		rdc("unmapped", 12'h0F0, 32'h0);
		apb(1'b1, `DSPIV_OFS_MASK, 32'hFFFF);
		rdc("mask", `DSPIV_OFS_MASK, 32'h3FFF);
		$display("test registers done");
		for (int s = 0; s < 2; s++) begin
			apb(1'b1, `DSPIV_OFS_DMACTL, s ? 32'hF : 32'h0);
			rdc("dmactl", `DSPIV_OFS_DMACTL, s ? 32'hF : 32'h0);
			for (int i = 0; i < 17; i++) begin
				pulsev(17'h1 << i);
				b = route(i, s);
				if (b < 0) begin
					none();
					rdc("flags", `DSPIV_OFS_FLAGS, 32'h0);
				end else
					take(5'(16 + b));
			end
		end
		apb(1'b1, `DSPIV_OFS_DMACTL, 32'h0);
		$display("test sources done");
		slow <= 1'b1;
		apb(1'b1, `DSPIV_OFS_MASK, 32'h0);
		pulsev(17'h02005);
		none();
		rdc("flags", `DSPIV_OFS_FLAGS, 32'h2005);
		apb(1'b1, `DSPIV_OFS_FLAGS, 32'h0004);
		rdc("flags", `DSPIV_OFS_FLAGS, 32'h2001);
		apb(1'b1, `DSPIV_OFS_MASK, 32'h2000);
		take(5'd29);
		pulsev(17'h00024);
		apb(1'b1, `DSPIV_OFS_MASK, 32'h3FFF);
		take(5'd16);
		take(5'd18);
		take(5'd21);
		$display("test priority done");
		apb(1'b1, `DSPIV_OFS_MASK, 32'h0);
		pulsev(17'h00001);
		@(posedge pclk);
		nmi <= 1'b1;
		take(5'd1);
		nmi <= 1'b0;
		apb(1'b1, `DSPIV_OFS_MASK, 32'h3FFF);
		take(5'd16);
		slow <= 1'b0;
		$display("test nmi done");
		apb(1'b1, `DSPIV_OFS_SWTRAP, 32'd5);
		take(5'd5);
		apb(1'b1, `DSPIV_OFS_SWTRAP, 32'd20);
		take(5'd20);
		apb(1'b1, `DSPIV_OFS_SWTRAP, 32'd30);
		none();
		rdc("status", `DSPIV_OFS_STATUS, 32'h0);
		rdc("swtrap", `DSPIV_OFS_SWTRAP, 32'h5);
		apb(1'b1, `DSPIV_OFS_SWTRAP, 32'd0);
		take(5'd0);
		$display("test software traps done");
		tally_and_finish();
	end
endmodule // dsp_interrupt_vectoring_tb_top

/* tb/dspiv_core_model.sv */
`timescale 1ns/1ns
// ----
// Core model, acks promptly or after three waits
// ----
module dspiv_core_model (
	// Clock and reset
	input  wire       pclk,
	input  wire       presetn,
	// Control
	input  wire       slow,
	// Core side
	input  wire       core_int_req,
	input  wire [4:0] core_int_trap,
	output reg        core_int_ack,
	// Record
	output reg  [4:0] taken_trap,
	output reg  [7:0] taken_cnt
);
	reg [1:0] wait_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_int_ack <= 1'b0;
			wait_q <= 2'd0;
			taken_trap <= 5'h1F;
			taken_cnt <= 8'h00;
		end else if (core_int_ack) begin
			core_int_ack <= 1'b0;
			wait_q <= 2'd0;
			taken_trap <= core_int_trap;
			taken_cnt <= taken_cnt + 8'h01;
		end else if (core_int_req) begin
			if (!slow || wait_q == 2'd3)
				core_int_ack <= 1'b1;
			else
				wait_q <= wait_q + 2'd1;
		end
	end
endmodule // dspiv_core_model

/* tb/dspiv_top_assertions.sv */
`timescale 1ns/1ns
// ----
// Checker
// ----
module dspiv_chk (
	// Clock and reset
	input wire        pclk,
	input wire        presetn,
	// APB
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	// Requests and core
	input wire        nmi_request,
	input wire        core_int_req,
	input wire [4:0]  core_int_trap,
	input wire [6:0]  core_int_vector,
	input wire        core_int_ack
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	a_vec_four_k: assert property (core_int_req |-> core_int_vector == {core_int_trap, 2'b00})
		else $error("vector not four times trap");
	a_trap_legal: assert property (core_int_req |-> core_int_trap < 5'd30)
		else $error("reserved trap presented");
	a_ack_drops_req: assert property (core_int_req && core_int_ack |=> !core_int_req)
		else $error("request held after ack");
	a_req_stands: assert property (core_int_req && !core_int_ack |=> core_int_req)
		else $error("request dropped before ack");
	a_nmi_taken: assert property ($rose(nmi_request) |-> ##[1:12] (core_int_req && core_int_trap == 5'd1))
		else $error("nmi not presented");
	a_rsv_zero: assert property (acc && !pwrite && paddr < 12'h008 |-> prdata[15:14] == 2'b00)
		else $error("reserved bits read nonzero");
	a_err_reads_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_err_decode: assert property (acc |-> pslverr == (paddr > 12'h010 || |paddr[1:0]))
		else $error("error flag does not match decode");
	c_ext_taken: cover property (core_int_ack && core_int_req && core_int_trap == 5'd16);
	c_nmi_taken: cover property (core_int_ack && core_int_req && core_int_trap == 5'd1);
	c_sw_taken: cover property (core_int_ack && core_int_req && core_int_trap == 5'd5);
	c_bad_addr: cover property (acc && pslverr);
endmodule // dspiv_chk

bind dspiv_top dspiv_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
	.pready, .pslverr, .nmi_request, .core_int_req, .core_int_trap, .core_int_vector,
	.core_int_ack);

/* verilog/dspiv_flag_cell.v */
`timescale 1ns/1ns

module dspiv_flag_cell (
	// Clock and reset
	input  wire pclk,
	input  wire presetn,
	// Control
	input  wire set_i,
	input  wire clr_i,
	// State
	output reg  flag_q
);

	// ----------------------------------------
	// Sticky flag, set wins
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= 1'b0;
		end else if (set_i) begin
			flag_q <= 1'b1;
		end else if (clr_i) begin
			flag_q <= 1'b0;
		end
	end

endmodule // dspiv_flag_cell

/* verilog/dspiv_prio_enc.v */
`timescale 1ns/1ns

module dspiv_prio_enc #(
	parameter N  = 14,
	parameter IW = 4
) (
	// Requests
	input  wire [N-1:0]  req_i,
	// Winner
	output reg           valid_o,
	output reg  [IW-1:0] idx_o
);

	integer i;

	// ----------------------------------------
	// Lowest index wins
	// ----------------------------------------
	always @* begin
		valid_o = 1'b0;
		idx_o   = {IW{1'b0}};
		for (i = N - 1; i >= 0; i = i - 1) begin
			if (req_i[i]) begin
				valid_o = 1'b1;
				idx_o   = i[IW-1:0];
			end
		end
	end

endmodule // dspiv_prio_enc

/* verilog/dspiv_regs.vh */
`ifndef DSPIV_REGS_VH
`define DSPIV_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DSPIV_OFS_FLAGS     12'h000
`define DSPIV_OFS_MASK      12'h004
`define DSPIV_OFS_DMACTL    12'h008
`define DSPIV_OFS_STATUS    12'h00C
`define DSPIV_OFS_SWTRAP    12'h010

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DSPIV_RST_FLAGS     16'h0000
`define DSPIV_RST_MASK      16'h0000
`define DSPIV_RST_DMACTL    16'h0000

// ----------------------------------------
// Flag and mask bit positions
// ----------------------------------------
`define DSPIV_BIT_EXT0      0
`define DSPIV_BIT_EXT1      1
`define DSPIV_BIT_EXT2      2
`define DSPIV_BIT_TIM0      3
`define DSPIV_BIT_SER0RX    4
`define DSPIV_BIT_SER0TX    5
`define DSPIV_BIT_SHARED6   6
`define DSPIV_BIT_SHARED7   7
`define DSPIV_BIT_EXT3      8
`define DSPIV_BIT_HOST      9
`define DSPIV_BIT_SHARED10  10
`define DSPIV_BIT_SHARED11  11
`define DSPIV_BIT_DMA4      12
`define DSPIV_BIT_DMA5      13
`define DSPIV_NUM_SRC       14
`define DSPIV_LIVE_BITS     16'h3FFF

// ----------------------------------------
// DMA control selection bits
// ----------------------------------------
`define DSPIV_DSEL_CH0      0
`define DSPIV_DSEL_CH1      1
`define DSPIV_DSEL_CH2      2
`define DSPIV_DSEL_CH3      3

// ----------------------------------------
// Trap numbers and vector spacing
// ----------------------------------------
`define DSPIV_TRAP_RESET    5'd0
`define DSPIV_TRAP_NMI      5'd1
`define DSPIV_TRAP_SW_LO    5'd2
`define DSPIV_TRAP_SW_HI    5'd15
`define DSPIV_TRAP_MASK_LO  5'd16
`define DSPIV_TRAP_MASK_HI  5'd29
`define DSPIV_VEC_SHIFT     2

`endif

/* verilog/dspiv_top.v */
// How it works
// - vector location is four times trap number; 2-15 unprioritised, 30-31 reserved.
// - reset is trap 0 at 00 priority 1; NMI trap 1 at 04 priority 2.
// - external request zero: trap 16, location 40, priority 3, bit 0.
// - external request one: trap 17, location 44, priority 4, bit 1.
// - external request two: trap 18, location 48, priority 5, bit 2.
// - timer zero: trap 19, location 4C, priority 6, bit 3.
// - serial zero receive: trap 20, location 50, priority 7, bit 4.
// - serial zero transmit: trap 21, location 54, priority 8, bit 5.
// - trap 22 bit 6 reserved, or DMA channel 0 when selected.
// - trap 23 bit 7 timer one, or DMA channel 1 when selected.
// - external request three: trap 24, location 60, priority 11, bit 8.
// - host port request: trap 25, location 64, priority 12, bit 9.
// - trap 26 bit 10 serial one receive, or DMA channel 2.
// - trap 27 bit 11 serial one transmit, or DMA channel 3.
// - DMA channel 4: trap 28, location 70, priority 15, bit 12.
// - DMA channel 5: trap 29, location 74, priority 16, bit 13.
// - flag and mask bits 15-14 reserved, no source.
// - flag and mask registers share one bit layout.
// - DMA select register sits directly in the register map.
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ns
`include "dspiv_regs.vh"

module dspiv_top (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output reg         pslverr,
	// Peripheral requests
	input  wire        nmi_request,
	input  wire        external_request_zero,
	input  wire        external_request_one,
	input  wire        external_request_two,
	input  wire        external_request_three,
	input  wire        timer_zero_request,
	input  wire        timer_one_request,
	input  wire        serial_zero_receive_request,
	input  wire        serial_zero_transmit_request,
	input  wire        serial_one_receive_request,
	input  wire        serial_one_transmit_request,
	input  wire        host_port_request,
	input  wire        dma_chan_zero_request,
	input  wire        dma_chan_one_request,
	input  wire        dma_chan_two_request,
	input  wire        dma_chan_three_request,
	input  wire        dma_chan_four_request,
	input  wire        dma_chan_five_request,
	// Core side
	output reg         core_int_req,
	output reg  [4:0]  core_int_trap,
	output reg  [6:0]  core_int_vector,
	input  wire        core_int_ack
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	localparam NSRC = `DSPIV_NUM_SRC;

	reg  [15:0]     dma_priority_enable_control;
	reg             reset_pend_q;
	reg             nmi_pend_q;
	reg             sw_pend_q;
	reg  [4:0]      sw_trap_q;
	reg             nmi_prev_q;
	reg  [4:0]      sel_trap_d;
	reg             sel_valid_d;
	reg  [31:0]     rdata_d;
	wire [NSRC-1:0] src_evt;
	wire [NSRC-1:0] sw_set;
	wire [NSRC-1:0] sw_clr;
	wire [NSRC-1:0] ack_clr;
	wire [NSRC-1:0] flag_bits;
	reg  [15:0]     interrupt_enable_mask;
	wire [15:0]     interrupt_pending_flags;
	wire [NSRC-1:0] pending_live;
	wire            win_valid;
	wire [3:0]      win_idx;
	wire            wr_en;
	wire            setup;
	wire            map_hit;
	wire            nmi_edge;
	wire            ack_take;
	wire [4:0]      sw_k;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	assign pready = 1'b1;
	assign setup  = psel & ~penable;
	assign wr_en  = psel & penable & pwrite;
	assign map_hit = (paddr == `DSPIV_OFS_FLAGS)  | (paddr == `DSPIV_OFS_MASK) |
	                 (paddr == `DSPIV_OFS_DMACTL) | (paddr == `DSPIV_OFS_STATUS) |
	                 (paddr == `DSPIV_OFS_SWTRAP);
	assign sw_k    = pwdata[4:0];

	// ----------------------------------------
	// Source selection per bit
	// ----------------------------------------
	assign src_evt[`DSPIV_BIT_EXT0]     = external_request_zero;
	assign src_evt[`DSPIV_BIT_EXT1]     = external_request_one;
	assign src_evt[`DSPIV_BIT_EXT2]     = external_request_two;
	assign src_evt[`DSPIV_BIT_TIM0]     = timer_zero_request;
	assign src_evt[`DSPIV_BIT_SER0RX]   = serial_zero_receive_request;
	assign src_evt[`DSPIV_BIT_SER0TX]   = serial_zero_transmit_request;
	assign src_evt[`DSPIV_BIT_SHARED6]  =
		dma_priority_enable_control[`DSPIV_DSEL_CH0] & dma_chan_zero_request;
	assign src_evt[`DSPIV_BIT_SHARED7]  =
		dma_priority_enable_control[`DSPIV_DSEL_CH1] ? dma_chan_one_request
		                                             : timer_one_request;
	assign src_evt[`DSPIV_BIT_EXT3]     = external_request_three;
	assign src_evt[`DSPIV_BIT_HOST]     = host_port_request;
	assign src_evt[`DSPIV_BIT_SHARED10] =
		dma_priority_enable_control[`DSPIV_DSEL_CH2] ? dma_chan_two_request
		                                             : serial_one_receive_request;
	assign src_evt[`DSPIV_BIT_SHARED11] =
		dma_priority_enable_control[`DSPIV_DSEL_CH3] ? dma_chan_three_request
		                                             : serial_one_transmit_request;
	assign src_evt[`DSPIV_BIT_DMA4]     = dma_chan_four_request;
	assign src_evt[`DSPIV_BIT_DMA5]     = dma_chan_five_request;

	// ----------------------------------------
	// Flag cells
	// ----------------------------------------
	assign ack_take = core_int_ack & core_int_req;

	genvar g;
	generate
		for (g = 0; g < NSRC; g = g + 1) begin : g_flag
			localparam integer KG = `DSPIV_TRAP_MASK_LO + g;
			// Software trap write raises the matching flag
			assign sw_set[g]  = wr_en & (paddr == `DSPIV_OFS_SWTRAP) &
			                    (sw_k == KG[4:0]);
			// Write one to clear
			assign sw_clr[g]  = wr_en & (paddr == `DSPIV_OFS_FLAGS) & pwdata[g];
			assign ack_clr[g] = ack_take & (core_int_trap == KG[4:0]);
			dspiv_flag_cell u_flag (
				.pclk    (pclk),
				.presetn (presetn),
				.set_i   (src_evt[g] | sw_set[g]),
				.clr_i   (sw_clr[g] | ack_clr[g]),
				.flag_q  (flag_bits[g])
			);
		end
	endgenerate

	assign interrupt_pending_flags = {2'b00, flag_bits};

	// ----------------------------------------
	// Mask and DMA select registers
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_enable_mask       <= `DSPIV_RST_MASK;
			dma_priority_enable_control <= `DSPIV_RST_DMACTL;
		end else if (wr_en) begin
			if (paddr == `DSPIV_OFS_MASK) begin
				interrupt_enable_mask <= pwdata[15:0] & `DSPIV_LIVE_BITS;
			end
			if (paddr == `DSPIV_OFS_DMACTL) begin
				dma_priority_enable_control <= pwdata[15:0];
			end
		end
	end

	// ----------------------------------------
	// Reset, NMI and software traps
	// ----------------------------------------
	assign nmi_edge = nmi_request & ~nmi_prev_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_pend_q <= 1'b1;
			nmi_pend_q   <= 1'b0;
			nmi_prev_q   <= 1'b0;
			sw_pend_q    <= 1'b0;
			sw_trap_q    <= 5'd0;
		end else begin
			nmi_prev_q <= nmi_request;
			if (wr_en & (paddr == `DSPIV_OFS_SWTRAP) & (sw_k == `DSPIV_TRAP_RESET)) begin
				reset_pend_q <= 1'b1;
			end else if (ack_take & (core_int_trap == `DSPIV_TRAP_RESET)) begin
				reset_pend_q <= 1'b0;
			end
			if (nmi_edge |
			    (wr_en & (paddr == `DSPIV_OFS_SWTRAP) & (sw_k == `DSPIV_TRAP_NMI))) begin
				nmi_pend_q <= 1'b1;
			end else if (ack_take & (core_int_trap == `DSPIV_TRAP_NMI)) begin
				nmi_pend_q <= 1'b0;
			end
			if (wr_en & (paddr == `DSPIV_OFS_SWTRAP) & ~sw_pend_q &
			    (sw_k >= `DSPIV_TRAP_SW_LO) & (sw_k <= `DSPIV_TRAP_SW_HI)) begin
				sw_pend_q <= 1'b1;
				sw_trap_q <= sw_k;
			end else if (ack_take & sw_pend_q & (core_int_trap == sw_trap_q)) begin
				sw_pend_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Arbitration
	// ----------------------------------------
	assign pending_live = flag_bits & interrupt_enable_mask[NSRC-1:0];

	dspiv_prio_enc #(
		.N  (NSRC),
		.IW (4)
	) u_enc (
		.req_i   (pending_live),
		.valid_o (win_valid),
		.idx_o   (win_idx)
	);

	always @* begin
		sel_valid_d = 1'b1;
		sel_trap_d  = `DSPIV_TRAP_RESET;
		if (reset_pend_q) begin
			sel_trap_d = `DSPIV_TRAP_RESET;
		end else if (nmi_pend_q) begin
			sel_trap_d = `DSPIV_TRAP_NMI;
		end else if (sw_pend_q) begin
			sel_trap_d = sw_trap_q;
		end else if (win_valid) begin
			sel_trap_d = `DSPIV_TRAP_MASK_LO + {1'b0, win_idx};
		end else begin
			sel_valid_d = 1'b0;
		end
	end

	// ----------------------------------------
	// Core presentation
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_int_req    <= 1'b0;
			core_int_trap   <= 5'd0;
			core_int_vector <= 7'h00;
		end else begin
			// One idle cycle after an acknowledge lets the flag clear settle
			core_int_req    <= sel_valid_d & ~ack_take;
			core_int_trap   <= sel_trap_d;
			core_int_vector <= {sel_trap_d, {`DSPIV_VEC_SHIFT{1'b0}}};
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always @* begin
		rdata_d = 32'h0000_0000;
		case (paddr)
			`DSPIV_OFS_FLAGS:  rdata_d = {16'h0000, interrupt_pending_flags};
			`DSPIV_OFS_MASK:   rdata_d = {16'h0000, interrupt_enable_mask};
			`DSPIV_OFS_DMACTL: rdata_d = {16'h0000, dma_priority_enable_control};
			`DSPIV_OFS_STATUS: rdata_d = {16'h0000, reset_pend_q, nmi_pend_q, sw_pend_q,
			                              core_int_req, 7'h00, sel_trap_d};
			`DSPIV_OFS_SWTRAP: rdata_d = {24'h000000, sw_pend_q, 2'b00, sw_trap_q};
			default:           rdata_d = 32'h0000_0000;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
			pslverr <= ~map_hit;
		end
	end

endmodule // dspiv_top
